// ---- verilog/dppp_top.sv ----
/*
  Post-processing path of a dual-channel converter: offset trim,
  fine gain, symmetric FIR with decimation, register file on
  AHB-Lite.
  Assumes samples arrive every clock from logic on clock_i and
  that one AHB-Lite master drives the register port.
*/
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [R1] Offset loop estimates and removes DC offset up to about 10 mV.
// [R2] Enabled loop updates estimate and subtracts it every clock.
// [R3] Time constant code picks 2^24..2^29 cycles; 110, 111 give 2^27.
// [R4] Freeze stops estimating but keeps applying last estimate.
// [R5] Offset correction is off after reset until enabled.
// [R6] Fine gain only raises, 0.05 dB steps to 0.5 dB, both channels.
// [R7] Gain code n up to 1010 adds n times 0.05 dB.
// [R8] Decimation filter off by default, runs once enabled.
// [R9] Rate 000 is by 2, 001 by 4, 100 by 8 custom only.
// [R10] By-2 built-in: band 00 low-pass, band 01 high-pass.
// [R11] By-4 built-in: bands 00..11 pick four quarter-band filters.
// [R12] Custom select ignores band; rate 011 undecimated custom filter.
// [R13] 24-tap symmetric FIR, twelve 12-bit coefficients, scaled 2^-11.
// [R14] Odd tap gives 23 taps, h11 once at the centre.
// [R15] Low-latency mode bypasses the whole processing path.
// [R16] Software loads custom coefficients as 12-bit values times 2^11.
// [R17] Undecimated custom filter is 12 taps of h6..h11, scaled 2^-11.
// [R18] Filter and gain results are rounded and saturated.
// [R19] Reset clears offset estimate and filter delay line.
module dppp_top
  import dppp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire dppp_pair_t  samp_i,
  output dppp_pair_t       samp_o,
  output logic             samp_valid_o
);
  logic                      take;
  logic [5:0]                idx;
  logic                      addr_ok;
  logic                      wr_pend_q;
  logic [5:0]                wr_idx_q;
  logic [5:0]                wr_coef;
  logic [5:0]                rd_coef;
  logic [31:0]               rd_d;
  logic [31:0]               hrdata_q;
  dppp_ctrl_t                ctrl_q;
  logic [7:0]                coef_q [`DPPP_NCOEF_B];
  logic signed [`DPPP_CW-1:0] h_user [`DPPP_HALF];
  logic signed [`DPPP_CW-1:0] h_sel  [`DPPP_HALF];
  logic [143:0]              tbl;
  dppp_taps_t                taps;
  logic [4:0]                shift;
  logic [14:0]               gmul;
  dppp_pair_t                trim_y;
  dppp_pair_t                gain_q;
  dppp_pair_t                fir_y;
  logic [`DPPP_W-1:0]        est_a;
  logic [`DPPP_W-1:0]        est_b;
  logic                      fir_on;
  logic                      nodec;
  logic [2:0]                mask;
  logic [2:0]                phase_q;
  logic                      strobe;
  dppp_mode_t                mode_d;
  dppp_mode_t                mode_q;

  // Fine gain in Q14 with rounding and clamp
  function automatic logic signed [`DPPP_W-1:0] apply_gain(
    input logic signed [`DPPP_W-1:0] x,
    input logic [14:0]               m
  );
    logic signed [31:0] p;
    p = 32'(x) * $signed(32'(m));
    return dppp_sat((p + `DPPP_GRND) >>> `DPPP_GAIN_FRAC); // [R18]
  endfunction : apply_gain

  // Bus decode: word index and mapped range
  assign take    = hsel_i & htrans_i[1] & hready_i;
  assign idx     = haddr_i[7:2];
  assign addr_ok = (haddr_i[31:8] == '0);
  assign wr_coef = wr_idx_q - `DPPP_IDX_COEF_LO;
  assign rd_coef = idx - `DPPP_IDX_COEF_LO;

  // Zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;

  // Address phase of a write, completed in the data phase
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= '0;
    end
    else
    begin
      wr_pend_q <= take & hwrite_i & addr_ok;
      wr_idx_q  <= idx;
    end
  end

  // Control register; everything processing starts off
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_q <= dppp_ctrl_t'(`DPPP_CTRL_RST); // [R5] [R8]
    else if (wr_pend_q && (wr_idx_q == `DPPP_IDX_CTRL))
      ctrl_q <= dppp_ctrl_t'(hwdata_i[`DPPP_CTRL_W-1:0]);
  end

  // Custom coefficient bytes, low byte lane only
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < `DPPP_NCOEF_B; i++)
        coef_q[i] <= '0;
    end
    else if (wr_pend_q && (wr_idx_q >= `DPPP_IDX_COEF_LO) &&
             (wr_idx_q <= `DPPP_IDX_COEF_HI))
      coef_q[wr_coef[4:0]] <= hwdata_i[7:0];
  end

  // Read data for the current address phase
  always_comb
  begin
    rd_d = '0;
    if (!addr_ok)
      rd_d = '0;
    else if (idx == `DPPP_IDX_CTRL)
      rd_d = 32'(ctrl_q);
    else if (idx == `DPPP_IDX_STAT)
      rd_d = {5'h00, est_b, 5'h00, est_a};
    else if ((idx >= `DPPP_IDX_COEF_LO) && (idx <= `DPPP_IDX_COEF_HI))
      rd_d = 32'(coef_q[rd_coef[4:0]]);
  end

  // Read data register, valid through the data phase
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hrdata_q <= '0;
    else if (take && !hwrite_i)
      hrdata_q <= rd_d;
  end

  // Unpack byte registers into twelve 12-bit coefficients
  always_comb
  begin
    for (int k = 0; k < `DPPP_HALF / 2; k++)
    begin
      h_user[2*k]   = {coef_q[3*k+1][3:0], coef_q[3*k]}; // [R16]
      h_user[2*k+1] = {coef_q[3*k+2], coef_q[3*k+1][7:4]};
    end
  end

  // Built-in set chosen by rate and band
  always_comb
  begin
    if (ctrl_q.rate == `DPPP_RATE_D4)
    begin
      case (ctrl_q.passband_select) // [R11]
        2'h0:    tbl = `DPPP_LP4;
        2'h1:    tbl = `DPPP_BP1;
        2'h2:    tbl = `DPPP_BP2;
        default: tbl = `DPPP_HP4;
      endcase
    end
    else if (ctrl_q.passband_select[0])
      tbl = `DPPP_HP2; // [R10]
    else
      tbl = `DPPP_LP2;
  end

  // Custom coefficients override the band choice
  always_comb
  begin
    for (int i = 0; i < `DPPP_HALF; i++)
      h_sel[i] = ctrl_q.user_taps_select ? h_user[i] :
                 tbl[i*`DPPP_CW +: `DPPP_CW]; // [R12]
  end

  // Mirror the half set into the full tap vector
  always_comb
  begin
    for (int i = 0; i < `DPPP_TAPS; i++)
      taps[i] = '0;
    if (nodec)
    begin
      for (int i = 0; i < `DPPP_HALF / 2; i++)
      begin
        taps[i]               = h_sel[i + `DPPP_HALF / 2]; // [R17]
        taps[`DPPP_HALF-1-i]  = h_sel[i + `DPPP_HALF / 2];
      end
    end
    else if (ctrl_q.odd_tap)
    begin
      for (int i = 0; i < `DPPP_HALF - 1; i++)
      begin
        taps[i]               = h_sel[i]; // [R14]
        taps[`DPPP_TAPS-2-i]  = h_sel[i];
      end
      taps[`DPPP_HALF-1] = h_sel[`DPPP_HALF-1];
    end
    else
    begin
      for (int i = 0; i < `DPPP_HALF; i++)
      begin
        taps[i]               = h_sel[i]; // [R13]
        taps[`DPPP_TAPS-1-i]  = h_sel[i];
      end
    end
  end

  // Offset loop time constant as a shift count
  always_comb
  begin
    case (ctrl_q.dc_trim_time_constant) // [R3]
      `DPPP_TC_0: shift = `DPPP_SH_27;
      `DPPP_TC_1: shift = `DPPP_SH_26;
      `DPPP_TC_2: shift = `DPPP_SH_25;
      `DPPP_TC_3: shift = `DPPP_SH_24;
      `DPPP_TC_4: shift = `DPPP_SH_28;
      `DPPP_TC_5: shift = `DPPP_SH_29;
      default:    shift = `DPPP_SH_27;
    endcase
  end

  // Gain multiplier; unused codes leave gain at unity
  always_comb
  begin
    case (ctrl_q.gain) // [R7]
      4'h0:    gmul = `DPPP_G0;
      4'h1:    gmul = `DPPP_G1;
      4'h2:    gmul = `DPPP_G2;
      4'h3:    gmul = `DPPP_G3;
      4'h4:    gmul = `DPPP_G4;
      4'h5:    gmul = `DPPP_G5;
      4'h6:    gmul = `DPPP_G6;
      4'h7:    gmul = `DPPP_G7;
      4'h8:    gmul = `DPPP_G8;
      4'h9:    gmul = `DPPP_G9;
      4'ha:    gmul = `DPPP_G10;
      default: gmul = `DPPP_G0;
    endcase
  end

  // Offset trim, one loop per channel
  dppp_dc_trim u_trim_a (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .en_i     (ctrl_q.ofs_en),
    .freeze_i (ctrl_q.ofs_freeze),
    .shift_i  (shift),
    .x_i      (samp_i.a),
    .y_o      (trim_y.a),
    .est_o    (est_a)
  );

  dppp_dc_trim u_trim_b (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .en_i     (ctrl_q.ofs_en),
    .freeze_i (ctrl_q.ofs_freeze),
    .shift_i  (shift),
    .x_i      (samp_i.b),
    .y_o      (trim_y.b),
    .est_o    (est_b)
  );

  // Common fine gain on both channels
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gain_q <= '0;
    else
    begin
      gain_q.a <= apply_gain(trim_y.a, gmul); // [R6]
      gain_q.b <= apply_gain(trim_y.b, gmul); // [R6]
    end
  end

  // FIR, one per channel
  dppp_fir u_fir_a (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .x_i     (gain_q.a),
    .taps_i  (taps),
    .y_o     (fir_y.a)
  );

  dppp_fir u_fir_b (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .x_i     (gain_q.b),
    .taps_i  (taps),
    .y_o     (fir_y.b)
  );

  // Filter runs when enabled or in undecimated custom mode
  assign nodec  = !ctrl_q.dec_en && ctrl_q.user_taps_select &&
                  (ctrl_q.rate == `DPPP_RATE_NODEC); // [R12]
  assign fir_on = ctrl_q.dec_en || nodec; // [R8]

  // Decimation phase mask; unsupported codes fall back to by 2
  always_comb
  begin
    if (nodec)
      mask = `DPPP_MASK_D1;
    else if (ctrl_q.rate == `DPPP_RATE_D4)
      mask = `DPPP_MASK_D4; // [R9]
    else if ((ctrl_q.rate == `DPPP_RATE_D8) && ctrl_q.user_taps_select)
      mask = `DPPP_MASK_D8; // [R9]
    else
      mask = `DPPP_MASK_D2; // [R9]
  end

  // Decimation phase counter
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      phase_q <= '0;
    else
      phase_q <= (phase_q + 3'h1) & mask;
  end

  assign strobe = (phase_q == '0);

  // Path selection; low latency wins over everything
  always_comb
  begin
    if (ctrl_q.low_latency)
      mode_d = DPPP_M_FAST; // [R15]
    else if (fir_on)
      mode_d = DPPP_M_FIR;
    else
      mode_d = DPPP_M_PLAIN;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mode_q <= DPPP_M_PLAIN;
    else
      mode_q <= mode_d;
  end

  // Output register and sample strobe
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      samp_o       <= '0;
      samp_valid_o <= 1'b0;
    end
    else
    begin
      unique case (mode_q)
        DPPP_M_FAST:
        begin
          samp_o       <= samp_i; // [R15]
          samp_valid_o <= 1'b1;
        end
        DPPP_M_PLAIN:
        begin
          samp_o       <= gain_q;
          samp_valid_o <= 1'b1;
        end
        DPPP_M_FIR:
        begin
          if (strobe)
            samp_o <= fir_y; // [R9]
          samp_valid_o <= strobe;
        end
      endcase
    end
  end
endmodule : dppp_top
`default_nettype wire

// ---- verilog/dppp_cfg.svh ----
/*
  Constants of the sample post-processing block: widths, register
  indices, control codes, shift counts, gain multipliers and the
  built-in filter coefficient sets.
  Assumes it is included by the package and the bench.
*/
`ifndef DPPP_CFG_SVH
`define DPPP_CFG_SVH

// Sample and coefficient widths
`define DPPP_W          11
`define DPPP_CW         12
`define DPPP_TAPS       24
`define DPPP_HALF       12
`define DPPP_FRAC       11
`define DPPP_ACC_W      41
`define DPPP_CTRL_W     18
`define DPPP_NCOEF_B    18
`define DPPP_RND        32'sh400
`define DPPP_MAX        11'sh3ff
`define DPPP_MIN        11'sh400

// Offset trim limit, in output codes (about 10 mV)
`define DPPP_OFS_MAX    11'sh00a
`define DPPP_OFS_MIN    11'sh7f6

// Register indices; byte address is four times the index
`define DPPP_IDX_CTRL   6'h00
`define DPPP_IDX_STAT   6'h01
`define DPPP_IDX_COEF_LO 6'h1e
`define DPPP_IDX_COEF_HI 6'h2f
`define DPPP_CTRL_RST   18'h00000

// Decimation rate codes
`define DPPP_RATE_D2    3'h0
`define DPPP_RATE_D4    3'h1
`define DPPP_RATE_D8    3'h4
`define DPPP_RATE_NODEC 3'h3
`define DPPP_MASK_D1    3'h0
`define DPPP_MASK_D2    3'h1
`define DPPP_MASK_D4    3'h3
`define DPPP_MASK_D8    3'h7

// Offset loop time constants as power-of-two shifts
`define DPPP_TC_0       3'h0
`define DPPP_TC_1       3'h1
`define DPPP_TC_2       3'h2
`define DPPP_TC_3       3'h3
`define DPPP_TC_4       3'h4
`define DPPP_TC_5       3'h5
`define DPPP_SH_24      5'h18
`define DPPP_SH_25      5'h19
`define DPPP_SH_26      5'h1a
`define DPPP_SH_27      5'h1b
`define DPPP_SH_28      5'h1c
`define DPPP_SH_29      5'h1d

// Gain multipliers, Q14, steps of 0.05 dB
`define DPPP_GAIN_FRAC  14
`define DPPP_GRND       32'sh2000
`define DPPP_G0         15'h4000
`define DPPP_G1         15'h405f
`define DPPP_G2         15'h40be
`define DPPP_G3         15'h411d
`define DPPP_G4         15'h417e
`define DPPP_G5         15'h41de
`define DPPP_G6         15'h4240
`define DPPP_G7         15'h42a2
`define DPPP_G8         15'h4304
`define DPPP_G9         15'h4367
`define DPPP_G10        15'h43cb

// Built-in coefficient sets, h11 in the top bits down to h0
`define DPPP_LP2 144'h3af111f3bf9c076023fc3fdc044ffafdb017
`define DPPP_HP2 144'h425d7cfd70ca026f95fdd04201efccfbffea
`define DPPP_LP4 144'h22a19e0ca008f9ff9cfd601802e047fcefef
`define DPPP_BP1 144'h20ef8fe30f4207505600004907ffd1013ff9
`define DPPP_BP2 144'h160dcd056126f4dffbfe403a02bf9bfdefde
`define DPPP_HP4 144'h23fe0b136f9ffc206afafff8016fa1ff1020

`endif

// ---- verilog/dppp_pkg.sv ----
/*
  Types and the saturation helper of the post-processing block.
  Assumes the constants header is on the include path.
*/
package dppp_pkg;
  `include "dppp_cfg.svh"

  // One sample of each channel
  typedef struct packed {
    logic signed [`DPPP_W-1:0] a;
    logic signed [`DPPP_W-1:0] b;
  } dppp_pair_t;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic       low_latency;
    logic       odd_tap;
    logic       user_taps_select;
    logic [1:0] passband_select;
    logic [2:0] rate;
    logic       dec_en;
    logic       ofs_freeze;
    logic       ofs_en;
    logic [2:0] dc_trim_time_constant;
    logic [3:0] gain;
  } dppp_ctrl_t;

  // Output path selection
  typedef enum logic [2:0] {
    DPPP_M_PLAIN = 3'b001,
    DPPP_M_FIR   = 3'b010,
    DPPP_M_FAST  = 3'b100
  } dppp_mode_t;

  typedef logic signed [`DPPP_CW-1:0] dppp_taps_t [`DPPP_TAPS];

  // Clamp a wide value to the sample range
  function automatic logic signed [`DPPP_W-1:0] dppp_sat(
    input logic signed [31:0] v
  );
    if (v > `DPPP_MAX)
      return `DPPP_MAX;
    else if (v < `DPPP_MIN)
      return `DPPP_MIN;
    else
      return v[`DPPP_W-1:0];
  endfunction : dppp_sat
endpackage : dppp_pkg

// ---- verilog/dppp_dc_trim.sv ----
/*
  Offset estimation and removal for one channel.
  Assumes one sample every clock, same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module dppp_dc_trim
  import dppp_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   en_i,
  input  wire logic                   freeze_i,
  input  wire logic [4:0]             shift_i,
  input  wire logic signed [`DPPP_W-1:0] x_i,
  output logic signed [`DPPP_W-1:0]   y_o,
  output logic signed [`DPPP_W-1:0]   est_o
);
  logic signed [`DPPP_ACC_W-1:0] acc_q;
  logic signed [`DPPP_ACC_W-1:0] est_w;
  logic signed [`DPPP_W-1:0]     est;
  logic signed [`DPPP_W:0]       err;
  logic                          hold;

  // Estimate is the accumulator scaled by the time constant
  assign est_w = acc_q >>> shift_i;

  // Correction limited to the trim range
  always_comb
  begin
    if (est_w > `DPPP_OFS_MAX)
      est = `DPPP_OFS_MAX;
    else if (est_w < `DPPP_OFS_MIN)
      est = `DPPP_OFS_MIN;
    else
      est = est_w[`DPPP_W-1:0];
  end

  // Error and anti-windup hold at the limits
  assign err  = {x_i[`DPPP_W-1], x_i} - {est[`DPPP_W-1], est};
  assign hold = ((est_w > `DPPP_OFS_MAX) && (err > 0)) ||
                ((est_w < `DPPP_OFS_MIN) && (err < 0));
  assign est_o = est;

  // Loop integrator, cleared while disabled
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      acc_q <= '0; // [R19]
    else if (!en_i)
      acc_q <= '0; // [R5]
    else if (!freeze_i && !hold)
      acc_q <= acc_q + `DPPP_ACC_W'(err); // [R2]
  end

  // Corrected sample; frozen estimate still applied
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      y_o <= '0;
    else if (en_i)
      y_o <= dppp_sat(32'(x_i) - 32'(est)); // [R1] [R4]
    else
      y_o <= x_i;
  end
endmodule : dppp_dc_trim
`default_nettype wire

// ---- verilog/dppp_fir.sv ----
/*
  Symmetric FIR core for one channel with a 24-entry delay line.
  Assumes the tap vector is already expanded by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module dppp_fir
  import dppp_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic signed [`DPPP_W-1:0] x_i,
  input  wire dppp_taps_t             taps_i,
  output logic signed [`DPPP_W-1:0]   y_o
);
  logic signed [`DPPP_W-1:0] line_q [`DPPP_TAPS];
  logic signed [31:0]        sum;

  // Delay line, newest sample at index 0
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < `DPPP_TAPS; i++)
        line_q[i] <= '0; // [R19]
    end
    else
    begin
      line_q[0] <= x_i;
      for (int i = 1; i < `DPPP_TAPS; i++)
        line_q[i] <= line_q[i-1];
    end
  end

  // Weighted sum over all taps
  always_comb
  begin
    sum = '0;
    for (int i = 0; i < `DPPP_TAPS; i++)
      sum = sum + 32'(line_q[i]) * 32'(taps_i[i]); // [R13]
  end

  // Scale by 2^-11 with rounding and clamp
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      y_o <= '0;
    else
      y_o <= dppp_sat((sum + `DPPP_RND) >>> `DPPP_FRAC); // [R18]
  end
endmodule : dppp_fir
`default_nettype wire

// ---- sim/dppp_top_asserts.sv ----
/*
  Checker of the post-processing top: sample path timing per mode.
  Assumes it is bound to dppp_top and that the control register
  sits at index 0 of the AHB-Lite register port.
*/
`timescale 1ns/10ps
`default_nettype none
module dppp_top_chk
  import dppp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire dppp_pair_t  samp_i,
  input  wire dppp_pair_t  samp_o,
  input  wire logic        samp_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic       wr_q;
  dppp_ctrl_t ctrl_q;
  logic [4:0] age_q;
  logic [3:0] gap_q;
  logic       settled;
  logic       plain;
  logic       filt;
  // Shadow of the control register and cycles since it was stored
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      wr_q   <= 1'b0;
      ctrl_q <= '0;
      age_q  <= 5'h00;
    end
    else
    begin
      wr_q   <= hsel_i & htrans_i[1] & hready_i & hwrite_i
                & (haddr_i[31:2] == 30'h0);
      if (wr_q)
        ctrl_q <= dppp_ctrl_t'(hwdata_i[17:0]);
      age_q  <= wr_q ? 5'h00 : age_q + {4'h0, age_q != 5'h1f};
    end
  // Cycles since the previous output strobe
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
      gap_q <= 4'h0;
    else if (samp_valid_o)
      gap_q <= 4'h0;
    else if (gap_q != 4'hf)
      gap_q <= gap_q + 4'h1;
  // Mode decode once the pipeline has seen a steady setting
  assign settled = age_q > 5'h14;
  assign plain   = settled & !ctrl_q.low_latency & !ctrl_q.dec_en
                   & !ctrl_q.user_taps_select & !ctrl_q.ofs_en;
  assign filt    = settled & !ctrl_q.low_latency & ctrl_q.dec_en;

  ll_bypass_a:
    assert property (settled & ctrl_q.low_latency
      |-> samp_o == $past(samp_i) && samp_valid_o)
    else $error("Bypass output differs");
  plain_unity_a:
    assert property (plain & ctrl_q.gain == 4'h0
      |-> samp_o == $past(samp_i, 3))
    else $error("Plain path altered sample");
  plain_valid_a:
    assert property (plain |-> samp_valid_o)
    else $error("Plain path strobe missing");
  gain_raise_a:
    assert property (plain & $signed($past(samp_i.a, 3)) >= 0
      |-> $signed(samp_o.a) >= $signed($past(samp_i.a, 3)))
    else $error("Gain lowered a sample");
  sat_clamp_a:
    assert property (plain & $past(samp_i.a, 3) == 11'h3ff
      |-> samp_o.a == 11'h3ff)
    else $error("Full scale wrapped");
  dec_two_a:
    assert property (filt & ctrl_q.rate == 3'h0 & samp_valid_o
      |-> gap_q == 4'h1)
    else $error("Strobe spacing not 2");
  dec_four_a:
    assert property (filt & ctrl_q.rate == 3'h1 & samp_valid_o
      |-> gap_q == 4'h3)
    else $error("Strobe spacing not 4");
  dec_eight_a:
    assert property (filt & ctrl_q.rate == 3'h4 & samp_valid_o
      & ctrl_q.user_taps_select |-> gap_q == 4'h7)
    else $error("Strobe spacing not 8");
  nodec_every_a:
    assert property (settled & !ctrl_q.low_latency & !ctrl_q.dec_en
      & ctrl_q.user_taps_select & ctrl_q.rate == 3'h3 |-> samp_valid_o)
    else $error("Undecimated strobe missing");

  cover property (filt & ctrl_q.rate == 3'h4 & samp_valid_o);
  cover property (settled & ctrl_q.low_latency);
  cover property (plain & ctrl_q.gain == 4'ha);
endmodule : dppp_top_chk

bind dppp_top dppp_top_chk u_chk (.clock_i, .rst_b_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .samp_i,
  .samp_o, .samp_valid_o);
`default_nettype wire

// ---- sim/dppp_core_model.sv ----
/*
  Converter core stand-in: one sample pair after every clock edge.
  Assumes the bench sets the levels and the toggle between edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dppp_core_model
  import dppp_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_b_i,
  input  wire logic signed [10:0] lvl_a_i,
  input  wire logic signed [10:0] lvl_b_i,
  input  wire logic               toggle_i,
  output dppp_pair_t              samp_o
);
  logic flip_q;
  // Toggle flips channel a sign each cycle so latency shows
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      flip_q <= 1'b0;
      samp_o <= '0;
    end
    else
    begin
      flip_q   <= ~flip_q;
      samp_o.a <= (toggle_i & flip_q) ? -lvl_a_i : lvl_a_i;
      samp_o.b <= lvl_b_i;
    end
endmodule : dppp_core_model
`default_nettype wire

// ---- sim/dppp_top_test.sv ----
/*
  Bench of the post-processing top: registers, gain, filters, offset.
  Assumes one AHB-Lite master here and the core model as sample source.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dppp_cfg.svh"
module dppp_top_test
  import dppp_pkg::*;
;
  logic               clock_i;
  logic               rst_b_i;
  logic               hsel, hwrite, hready, tog;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata;
  logic signed [10:0] lvl_a, lvl_b;
  dppp_pair_t         samp_in, samp_out;
  int                 num_errors = 0;
  int                 checks_done = 0;
  int                 cycles = 0;
  logic [11:0]        coef [12] = '{12'hf00, 12'h0, 12'h0, 12'h0,
                        12'h0, 12'h0, 12'h100, 12'h0, 12'h0, 12'h0,
                        12'h0, 12'h200};
  logic [31:0]        fmode [7] = '{32'h200, 32'h2200, 32'h10200,
                        32'h600, 32'h2600, 32'h4600, 32'h6600};
  int                 fexp [7] = '{999, 421, 539, 989, 124, -108, 182};
  logic [31:0]        cmode [7] = '{32'h8200, 32'he200, 32'h8600,
                        32'h9200, 32'h18200, 32'h8c00, 32'h18c00};
  int                 cexp [7] = '{500, 500, 500, 500, 250, 750, 750};

  dppp_top u_dut (.clock_i, .rst_b_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .samp_i(samp_in),
    .samp_o(samp_out), .samp_valid_o());
  dppp_core_model u_core (.clock_i, .rst_b_i, .lvl_a_i(lvl_a),
    .lvl_b_i(lvl_b), .toggle_i(tog), .samp_o(samp_in));

  // 250 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Hang guard
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single-word transfer, address then data phase
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, idx, 2'h0};
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic put(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask : put
  task automatic get(input logic [5:0] idx, input logic [31:0] e,
                     input string what);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    check(what, r, e);
  endtask : get
  // Outputs are looked at mid-cycle, clear of the edge
  task automatic expect_out(input int n, input int ea, input int eb);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
    check("channel a", 32'(samp_out.a), 32'(ea));
    check("channel b", 32'(samp_out.b), 32'(eb));
    @(posedge clock_i);
  endtask : expect_out
  task automatic run(input logic [31:0] ctrl, input int ea, input int eb);
    put(`DPPP_IDX_CTRL, ctrl);
    expect_out(60, ea, eb);
  endtask : run
  function automatic int gained(input int x, input int n);
    real g;
    g = $itor(x) * 10.0 ** (n * 0.0025);
    return g < 0 ? -$rtoi(0.5 - g) : $rtoi(g + 0.5);
  endfunction : gained
  function automatic logic [31:0] coef_byte(input int j);
    logic [11:0] lo, hi;
    lo = coef[2 * (j / 3)];
    hi = coef[2 * (j / 3) + 1];
    case (j % 3)
      0: return {24'h0, lo[7:0]};
      1: return {24'h0, hi[3:0], lo[11:8]};
      default: return {24'h0, hi[11:4]};
    endcase
  endfunction : coef_byte
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    rst_b_i = 1'b0;
    {hsel, hwrite, tog, htrans} = '0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    lvl_a = 11'sd900;
    lvl_b = -11'sd900;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    get(`DPPP_IDX_CTRL, 32'h0, "control");
    get(`DPPP_IDX_STAT, 32'h0, "estimate");
    put(`DPPP_IDX_CTRL, 32'hffffffff);
    get(`DPPP_IDX_CTRL, 32'h3ffff, "control");
    get(6'h3f, 32'h0, "unmapped");
    tog <= 1'b1;
    put(`DPPP_IDX_CTRL, 32'h0);
    repeat (40) @(posedge clock_i);
    put(`DPPP_IDX_CTRL, 32'h2020a);
    tog <= 1'b0;
    expect_out(40, 900, -900);
    for (int n = 0; n <= 10; n++)
      run(n, gained(900, n), gained(-900, n));
    lvl_a <= 11'sd1023;
    lvl_b <= -11'sd1024;
    run(32'ha, 1023, -1024);
    lvl_a <= 11'sd1000;
    lvl_b <= -11'sd1000;
    for (int i = 0; i < 7; i++)
      run(fmode[i], fexp[i], -fexp[i]);
    for (int j = 0; j < 18; j++)
      put(`DPPP_IDX_COEF_LO + 6'(j), coef_byte(j));
    get(6'h1f, 32'hf, "coefficient");
    for (int i = 0; i < 7; i++)
      run(cmode[i], cexp[i], -cexp[i]);
    lvl_b <= 11'sd0;
    put(`DPPP_IDX_CTRL, 32'hb0);
    expect_out(20000, 999, 0);
    get(`DPPP_IDX_STAT, 32'h1, "estimate");
    put(`DPPP_IDX_CTRL, 32'h1b0);
    expect_out(20000, 999, 0);
    get(`DPPP_IDX_STAT, 32'h1, "estimate");
    put(`DPPP_IDX_CTRL, 32'h0);
    expect_out(20, 1000, 0);
    tally_and_finish();
  end
endmodule : dppp_top_test
`default_nettype wire
